// ==== src/addr_select_top.sv ====
// holds: target address selection for the management-bus port, straps, latch and ack
// assumes: scl_i is the link clock from the bus host; straps are stable pins at power-up
// Function
// - device is target only; host drives clock, device only pulls data low
// - fixed variant answers only at 0x2e whatever the straps
// - address byte is seven address bits then direction, write form 0x5c
// - selectable variant with strap high at power-up uses 0x2e
// - strap low at power-up enters select mode, select input picks address
// - strap and select sampled once after power-up, never again
// - address latched at rising edge opening eighth pulse of first matching byte
// - after latch strap changes are ignored until next power-up
// - select mode: select low gives 0x2c, select high gives 0x2d
`timescale 1ns/10ps
module addr_select_top
#(
	parameter bit FIXED_VARIANT = 1'b0
)
(
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic address_enable_strap_i,
	input wire logic address_select_i,
	output addr_sel_pkg::target_status_t status_o
);
	import addr_sel_pkg::*;

	// ----------------------------------------
	// strap synchronisers and power-up capture
	// ----------------------------------------
	logic [1:0] strap_sync_reg;
	logic [1:0] strap_sync_next;
	logic [1:0] sel_sync_reg;
	logic [1:0] sel_sync_next;
	logic sampled_reg;
	logic sampled_next;
	strap_t strap_reg;
	strap_t strap_next;
	logic [6:0] sel_addr_reg;
	logic [6:0] sel_addr_next;

	always_comb
	begin
		strap_sync_next = {strap_sync_reg[0], address_enable_strap_i};
		sel_sync_next = {sel_sync_reg[0], address_select_i};
		sampled_next = sampled_reg;
		strap_next = strap_reg;
		sel_addr_next = sel_addr_reg;
		if (!sampled_reg)
		begin
			// single capture after power-up, never revisited
			sampled_next = 1'b1;
			strap_next.strap_high = strap_sync_reg[1];
			strap_next.select_high = sel_sync_reg[1];
			strap_next.fixed_variant = FIXED_VARIANT;
			if (FIXED_VARIANT)
				sel_addr_next = FIXED_ADDR;
			else if (strap_sync_reg[1])
				sel_addr_next = FIXED_ADDR;
			else if (sel_sync_reg[1])
				sel_addr_next = SEL_HIGH_ADDR;
			else
				sel_addr_next = SEL_LOW_ADDR;
		end
	end

	// three-cycle settle count from SYNC_RESET before capture is allowed
	logic [1:0] settle_reg;
	logic [1:0] settle_next;
	always_comb
	begin
		settle_next = settle_reg;
		if (settle_reg != 2'h0)
			settle_next = settle_reg - 2'h1;
	end

	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			strap_sync_reg <= 2'h0;
			sel_sync_reg <= 2'h0;
			settle_reg <= SYNC_RESET;
			sampled_reg <= 1'b0;
			strap_reg <= '0;
			sel_addr_reg <= FIXED_ADDR;
		end
		else
		begin
			strap_sync_reg <= strap_sync_next;
			sel_sync_reg <= sel_sync_next;
			settle_reg <= settle_next;
			sampled_reg <= (settle_reg == 2'h0) ? sampled_next : 1'b0;
			strap_reg <= (settle_reg == 2'h0) ? strap_next : strap_reg;
			sel_addr_reg <= (settle_reg == 2'h0) ? sel_addr_next : sel_addr_reg;
		end
	end

	// ----------------------------------------
	// link side: reset bridge and address hold
	// ----------------------------------------
	logic [1:0] ready_sync_reg;
	logic link_rst_n;
	logic latched_reg;
	logic latched_next;
	logic [6:0] latch_addr_reg;
	logic [6:0] latch_addr_next;
	logic latch_pulse;
	logic [7:0] addr_byte;
	logic frame;
	logic [6:0] target_addr;

	// sampled_reg is quasi-static after power-up; synchronised into scl domain
	always_ff @(posedge scl_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			ready_sync_reg <= 2'h0;
		else
			ready_sync_reg <= {ready_sync_reg[0], sampled_reg};
	end

	assign link_rst_n = ready_sync_reg[1];
	assign target_addr = latched_reg ? latch_addr_reg : sel_addr_reg;

	always_comb
	begin
		latched_next = latched_reg;
		latch_addr_next = latch_addr_reg;
		if (latch_pulse && !latched_reg)
		begin
			latched_next = 1'b1;
			latch_addr_next = sel_addr_reg;
		end
	end

	// held until next power-up; strap changes no longer reach target_addr
	always_ff @(posedge scl_i or negedge link_rst_n)
	begin
		if (!link_rst_n)
		begin
			latched_reg <= 1'b0;
			latch_addr_reg <= 7'h00;
		end
		else
		begin
			latched_reg <= latched_next;
			latch_addr_reg <= latch_addr_next;
		end
	end

	addr_byte_engine u_engine
	(
		.scl_i(scl_i),
		.sda_i(sda_i),
		.por_n_i(link_rst_n),
		.target_addr_i(target_addr),
		.sda_oe_o(sda_oe_o),
		.latch_pulse_o(latch_pulse),
		.addr_byte_o(addr_byte),
		.frame_o(frame)
	);

	// open-drain: only ever pulls low, never drives scl
	assign sda_o = 1'b0;

	// ----------------------------------------
	// status back into clk domain
	// ----------------------------------------
	logic [1:0] lat_sync_reg;
	logic [1:0] lat_sync_next;
	target_status_t status_reg;
	target_status_t status_next;

	always_comb
	begin
		lat_sync_next = {lat_sync_reg[0], latched_reg};
		status_next.addr_latched = lat_sync_reg[1];
		status_next.addr = lat_sync_reg[1] ? latch_addr_reg : sel_addr_reg;
		// write-form byte of the active address: address then direction zero
		status_next.addr_match = ({status_reg.addr, 1'b0} == {sel_addr_reg, 1'b0});
	end

	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			lat_sync_reg <= 2'h0;
			status_reg <= '0;
		end
		else
		begin
			lat_sync_reg <= lat_sync_next;
			status_reg <= status_next;
		end
	end

	assign status_o = status_reg;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	AST_FIXED_ADDR: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(FIXED_VARIANT && sampled_reg) |-> sel_addr_reg == FIXED_ADDR)
		else $error("fixed variant address wrong");
	AST_STRAP_HIGH: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(!FIXED_VARIANT && sampled_reg && strap_reg.strap_high) |-> sel_addr_reg == FIXED_ADDR)
		else $error("strap high address wrong");
	AST_SEL_MAP: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(!FIXED_VARIANT && sampled_reg && !strap_reg.strap_high) |->
		sel_addr_reg == (strap_reg.select_high ? SEL_HIGH_ADDR : SEL_LOW_ADDR))
		else $error("select mode address wrong");
	AST_SAMPLE_ONCE: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		$past(sampled_reg) && sampled_reg |-> $stable(sel_addr_reg) && $stable(strap_reg))
		else $error("straps re-evaluated");
	AST_SAMPLED_HOLD: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		sampled_reg |=> sampled_reg)
		else $error("capture flag dropped");
	AST_LATCH_HOLD: assert property (@(posedge scl_i) disable iff (!link_rst_n)
		latched_reg |=> latched_reg && $stable(latch_addr_reg))
		else $error("latched address changed");
	AST_LATCH_CAUSE: assert property (@(posedge scl_i) disable iff (!link_rst_n)
		(latch_pulse && !latched_reg) |=> latched_reg && latch_addr_reg == $past(sel_addr_reg))
		else $error("address not latched on match");
	AST_ACK_MATCH: assert property (@(posedge scl_i) disable iff (!link_rst_n)
		sda_oe_o |-> addr_byte[7:1] == target_addr)
		else $error("ack on foreign address");
	AST_NO_DRIVE_HIGH: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		sda_o == 1'b0)
		else $error("data line driven high");

endmodule // addr_select_top

// ==== src/addr_sel_pkg.sv ====
// package: constants and carrier types for the management-bus target address logic
// assumes: imported by the address select top and its bus-side engine
package addr_sel_pkg;
	localparam logic [6:0] FIXED_ADDR = 7'h2e;
	localparam logic [6:0] SEL_LOW_ADDR = 7'h2c;
	localparam logic [6:0] SEL_HIGH_ADDR = 7'h2d;
	localparam logic [7:0] FIXED_WRITE_BYTE = 8'h5c;
	localparam int BYTE_BITS = 8;
	localparam logic [3:0] LATCH_BIT_IDX = 4'h7;
	localparam logic [3:0] ACK_BIT_IDX = 4'h8;
	localparam logic [1:0] SYNC_RESET = 2'h3;
	typedef struct packed {
		logic strap_high;
		logic select_high;
		logic fixed_variant;
	} strap_t;
	typedef struct packed {
		logic scl;
		logic sda;
	} bus_pins_t;
	typedef struct packed {
		logic addr_match;
		logic addr_latched;
		logic [6:0] addr;
	} target_status_t;
endpackage

// ==== src/addr_byte_engine.sv ====
// holds: bus-side engine that tracks start, stop, bit count and drives the address ack
// assumes: scl and sda come in raw on the scl clock; target address is static while in use
`timescale 1ns/10ps
module addr_byte_engine
(
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic por_n_i,
	input wire logic [6:0] target_addr_i,
	output logic sda_oe_o,
	output logic latch_pulse_o,
	output logic [7:0] addr_byte_o,
	output logic frame_o
);
	import addr_sel_pkg::*;

	logic start_tog_reg;
	logic stop_tog_reg;
	logic start_seen_reg;
	logic [3:0] bit_cnt_reg;
	logic [3:0] bit_cnt_next;
	logic [7:0] shift_reg;
	logic [7:0] shift_next;
	logic first_byte_reg;
	logic first_byte_next;
	logic ack_reg;
	logic ack_next;
	logic latch_reg;
	logic latch_next;
	logic start_pend;

	// ----------------------------------------
	// start and stop detection on sda edges
	// ----------------------------------------
	always_ff @(negedge sda_i or negedge por_n_i)
	begin
		if (!por_n_i)
			start_tog_reg <= 1'b0;
		else if (scl_i)
			start_tog_reg <= ~start_tog_reg;
	end

	always_ff @(posedge sda_i or negedge por_n_i)
	begin
		if (!por_n_i)
			stop_tog_reg <= 1'b0;
		else if (scl_i)
			stop_tog_reg <= ~stop_tog_reg;
	end

	always_ff @(posedge scl_i or negedge por_n_i)
	begin
		if (!por_n_i)
			start_seen_reg <= 1'b0;
		else
			start_seen_reg <= start_tog_reg;
	end

	assign start_pend = start_tog_reg ^ start_seen_reg;
	assign frame_o = first_byte_reg;

	// ----------------------------------------
	// bit counting and address compare
	// ----------------------------------------
	always_comb
	begin
		bit_cnt_next = bit_cnt_reg;
		shift_next = shift_reg;
		first_byte_next = first_byte_reg;
		latch_next = 1'b0;
		if (start_pend)
		begin
			bit_cnt_next = 4'h1;
			shift_next = {7'h00, sda_i};
			first_byte_next = 1'b1;
		end
		else if (first_byte_reg)
		begin
			shift_next = {shift_reg[6:0], sda_i};
			if (bit_cnt_reg == ACK_BIT_IDX)
			begin
				first_byte_next = 1'b0;
				bit_cnt_next = 4'h0;
			end
			else
			begin
				bit_cnt_next = bit_cnt_reg + 4'h1;
			end
			// rising edge opening the seventh pulse: seven address bits are in
			if ((bit_cnt_reg == LATCH_BIT_IDX - 4'h1) && (shift_next[6:0] == target_addr_i))
				latch_next = 1'b1;
		end
	end

	always_ff @(posedge scl_i or negedge por_n_i)
	begin
		if (!por_n_i)
		begin
			bit_cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			first_byte_reg <= 1'b0;
			latch_reg <= 1'b0;
		end
		else
		begin
			bit_cnt_reg <= bit_cnt_next;
			shift_reg <= shift_next;
			first_byte_reg <= first_byte_next;
			latch_reg <= latch_next;
		end
	end

	// ack is driven during the low phase before the ninth pulse
	always_comb
	begin
		ack_next = 1'b0;
		if (first_byte_reg && (bit_cnt_reg == BYTE_BITS[3:0]) && (shift_reg[7:1] == target_addr_i))
			ack_next = 1'b1;
	end

	always_ff @(negedge scl_i or negedge por_n_i)
	begin
		if (!por_n_i)
			ack_reg <= 1'b0;
		else
			ack_reg <= ack_next;
	end

	assign sda_oe_o = ack_reg;
	assign latch_pulse_o = latch_reg;
	assign addr_byte_o = shift_reg;

endmodule // addr_byte_engine

// ==== tb/smbus_host_model.sv ====
// holds: behavioural bus host driving scl and the host side of sda
// assumes: sda wire has a pull-up; data 1 means released
`timescale 1ns/10ps
module smbus_host_model
(
	output logic scl_o,
	output logic sda_o,
	input wire logic sda_wire_i
);
	// ----------------------------------------
	// idle levels
	// ----------------------------------------
	initial
	begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	// ----------------------------------------
	// bus cycles
	// ----------------------------------------
	task automatic bit_out(input logic b);
	begin
		sda_o = b;
		#20 scl_o = 1'b1;
		#40 scl_o = 1'b0;
		#20;
	end
	endtask
	// clock pulses with data released, no start
	task automatic idle(input int n);
	begin
		repeat (n)
		begin
			#40 scl_o = 1'b0;
			#40 scl_o = 1'b1;
		end
		#40;
	end
	endtask
	// host drives clock, device only answers
	task automatic frame(input logic [7:0] b, output logic ack);
	begin
		#40 sda_o = 1'b0;
		#40 scl_o = 1'b0;
		#20;
		for (int i = 7; i >= 0; i--)
		begin
			bit_out(b[i]);
		end
		sda_o = 1'b1;
		#20 scl_o = 1'b1;
		#20 ack = ~sda_wire_i;
		#20 scl_o = 1'b0;
		#20 sda_o = 1'b0;
		#20 scl_o = 1'b1;
		#40 sda_o = 1'b1;
		#40;
	end
	endtask
endmodule // smbus_host_model

// ==== tb/tb_top.sv ====
// holds: self-checking bench for the target address select logic
// assumes: host model on the link; straps applied around each reset
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin bad_count++; \
	$display("BAD %s exp %h got %h", nm, ex, gt); end end
module tb_top;
	import addr_sel_pkg::*;
	logic clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic strap = 1'b1;
	logic sel = 1'b0;
	logic scl;
	logic host_sda;
	logic sda_o;
	logic sda_oe_o;
	wire sda_w;
	target_status_t status;
	int bad_count = 0;
	int total_checks = 0;
	assign sda_w = host_sda & ~(sda_oe_o & ~sda_o);
	always #10 clk_i = ~clk_i;
	addr_select_top #(.FIXED_VARIANT(1'b0)) u_addr_select_top (.clk_i(clk_i), .reset_n_i(reset_n_i),
		.scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
		.address_enable_strap_i(strap), .address_select_i(sel), .status_o(status));
	smbus_host_model host (.scl_o(scl), .sda_o(host_sda), .sda_wire_i(sda_w));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic report_and_stop();
	begin
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	end
	endtask
	task automatic power_up(input logic st, input logic se);
	begin
		@(negedge clk_i);
		reset_n_i = 1'b0;
		strap = st;
		sel = se;
		repeat (6) @(negedge clk_i);
		reset_n_i = 1'b1;
		repeat (8) @(negedge clk_i);
		host.idle(4);
	end
	endtask
	task automatic probe(input logic [7:0] b, input logic exp_ack);
		logic ack;
	begin
		host.frame(b, ack);
		`CHK("address ack", exp_ack, ack)
		`CHK("data drive level", 1'b0, sda_o)
	end
	endtask
	task automatic wait_latch(input logic [6:0] exp_addr);
		int n;
	begin
		n = 0;
		while (status.addr_latched !== 1'b1 && n < 40)
		begin
			@(negedge clk_i);
			n++;
		end
		`CHK("latched", 1'b1, status.addr_latched)
		`CHK("address", exp_addr, status.addr)
		`CHK("address match", 1'b1, status.addr_match)
		if (n >= 40)
			report_and_stop();
	end
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic scenario_default();
	begin
		power_up(1'b1, 1'b0);
		`CHK("latched early", 1'b0, status.addr_latched)
		probe(8'h58, 1'b0);
		`CHK("latched on miss", 1'b0, status.addr_latched)
		probe(FIXED_WRITE_BYTE, 1'b1);
		wait_latch(FIXED_ADDR);
		probe(8'h5d, 1'b1);
	end
	endtask
	task automatic scenario_sel_low();
	begin
		power_up(1'b0, 1'b0);
		probe(8'h5c, 1'b0);
		probe(8'h58, 1'b1);
		wait_latch(SEL_LOW_ADDR);
		@(negedge clk_i);
		strap = 1'b1;
		sel = 1'b1;
		probe(8'h5a, 1'b0);
		probe(8'h58, 1'b1);
		probe(8'h5c, 1'b0);
	end
	endtask
	task automatic scenario_sel_high();
	begin
		power_up(1'b0, 1'b1);
		@(negedge clk_i);
		sel = 1'b0;
		probe(8'h58, 1'b0);
		probe(8'h5a, 1'b1);
		wait_latch(SEL_HIGH_ADDR);
	end
	endtask
	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial
	begin
		scenario_default();
		scenario_sel_low();
		scenario_sel_high();
		report_and_stop();
	end
	initial
	begin
		#1500000;
		`CHK("watchdog", 1'b0, 1'b1)
		report_and_stop();
	end
endmodule // tb_top
